/* hw/pms_top.sv */
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "pms_cfg.svh"

// Summary of operation
// - read-only bit 0 of select register 1 mirrors the strap pin.
// - software writes never change the strap bit.
// - strap low means no PCI function and pull resistors enabled.
// - strap low turns the shared GPIO-block pins into GPIO 3 to 0.
// - strap low leaves PCI data-block pins without any function.
// - strap high disables pulls and routes GPIO-block and PCI data-block pins to PCI.
// - memory-shared pins go PCI only when memory pin mode is 000 or 101.
// - host-group pins take their function from host select and strap.
// - memory-group shared pins take their function from memory pin mode.
// - memory sub-blocks 0, 3 and host group use strap with other fields.
// - strap high with host select 000 gives PCI; strap high with any other select, or strap low with select 101 to 111, is reserved.
module pms_top (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pci_mode_strap,
    output logic ipull_en,
    output logic gpio_blk_pci,
    output logic pci_data_en,
    output logic emem_pci,
    output logic [2:0] emem_mode,
    output pms_pkg::pms_host_fn_t host_fn,
    output logic host_rsvd
);

    // ----------------------------------------
    // decode functions
    // ----------------------------------------
    function automatic logic aem_pci_ok(input logic [2:0] m);
        aem_pci_ok = (m == `PMS_MEM_PCI_A) || (m == `PMS_MEM_PCI_B);
    endfunction

    function automatic pms_pkg::pms_host_fn_t host_decode(
        input logic strap,
        input logic [2:0] hs
    );
        pms_pkg::pms_host_fn_t f;
        f = pms_pkg::PMS_HOST_RSVD;
        if (strap) begin
            if (hs == `PMS_HSEL_PCI) begin
                f = pms_pkg::PMS_HOST_PCI;
            end
        end else begin
            unique case (hs)
                3'h0: f = pms_pkg::PMS_HOST_GPIO;
                3'h1: f = pms_pkg::PMS_HOST_HPI;
                3'h2: f = pms_pkg::PMS_HOST_LINK;
                3'h3: f = pms_pkg::PMS_HOST_LINK_MII;
                3'h4: f = pms_pkg::PMS_HOST_MII;
                default: f = pms_pkg::PMS_HOST_RSVD;
            endcase
        end
        host_decode = f;
    endfunction

    // ----------------------------------------
    // strap synchroniser
    // ----------------------------------------
    // the board keeps the strap static, so a plain two-flop
    // synchroniser is enough; a moving strap would glitch pin
    // ownership and is not supported
    logic strap_s1_q;
    logic strap_s2_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            strap_s1_q <= 1'b0;
            strap_s2_q <= 1'b0;
        end else begin
            strap_s1_q <= pci_mode_strap;
            strap_s2_q <= strap_s1_q;
        end
    end

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [2:0] mem_mode_q;
    logic [2:0] mem_mode_d;
    logic [2:0] hsel_q;
    logic [2:0] hsel_d;

    // one wait state: taken on the first access cycle, answered on the
    // second; a write lands on the edge where the master sees pready
    wire take = psel && penable && !pready_q;
    wire acc_end = psel && penable && pready_q;
    wire hit0 = (paddr == `PMS_OFF_SEL0);
    wire hit1 = (paddr == `PMS_OFF_SEL1);
    wire wr0 = acc_end && pwrite && hit0;
    wire wr1 = acc_end && pwrite && hit1;
    wire [31:0] rd0 = {29'h0, mem_mode_q};
    // reserved bits read as zero; bit 0 reads the second strap synchroniser flop
    wire [31:0] rd1 = {25'h0, hsel_q, 3'h0, strap_s2_q};
    wire [31:0] rd_mux = hit0 ? rd0 : (hit1 ? rd1 : 32'h0000_0000);

    assign mem_mode_d = wr0 ? pwdata[`PMS_MEM_MODE_MSB:`PMS_MEM_MODE_LSB]
                            : mem_mode_q;
    assign hsel_d = wr1 ? pwdata[`PMS_HSEL_MSB:`PMS_HSEL_LSB] : hsel_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= take;
            pslverr_q <= take && !hit0 && !hit1;
            prdata_q <= (take && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // register fields
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mem_mode_q <= `PMS_MEM_MODE_RST;
            hsel_q <= `PMS_HSEL_RST;
        end else begin
            mem_mode_q <= mem_mode_d;
            hsel_q <= hsel_d;
        end
    end

    // ----------------------------------------
    // pin steering
    // ----------------------------------------
    // outputs are flopped from the next-state fields so they change on
    // the same edge as a write; the strap comes only from the second
    // synchroniser flop, so pins follow the read bit one edge later
    wire strap_d = strap_s2_q;
    wire pull_d = !strap_d;
    wire emem_pci_d = strap_d && aem_pci_ok(mem_mode_d);
    pms_pkg::pms_host_fn_t host_fn_d;
    assign host_fn_d = host_decode(strap_d, hsel_d);
    wire host_rsvd_d = (host_fn_d == pms_pkg::PMS_HOST_RSVD);

    logic ipull_q;
    logic gpio_blk_pci_q;
    logic pci_data_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ipull_q <= 1'b1;
            gpio_blk_pci_q <= 1'b0;
            pci_data_q <= 1'b0;
        end else begin
            ipull_q <= pull_d;
            gpio_blk_pci_q <= strap_d;
            pci_data_q <= strap_d;
        end
    end

    // ----------------------------------------
    // memory group
    // ----------------------------------------
    logic emem_pci_q;
    logic [2:0] emem_mode_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            emem_pci_q <= 1'b0;
            emem_mode_q <= `PMS_MEM_MODE_RST;
        end else begin
            emem_pci_q <= emem_pci_d;
            emem_mode_q <= mem_mode_d;
        end
    end

    // ----------------------------------------
    // host group
    // ----------------------------------------
    pms_pkg::pms_host_fn_t host_fn_q;
    logic host_rsvd_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            host_fn_q <= pms_pkg::PMS_HOST_GPIO;
            host_rsvd_q <= 1'b0;
        end else begin
            host_fn_q <= host_fn_d;
            host_rsvd_q <= host_rsvd_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign ipull_en = ipull_q;
    assign gpio_blk_pci = gpio_blk_pci_q;
    assign pci_data_en = pci_data_q;
    assign emem_pci = emem_pci_q;
    assign emem_mode = emem_mode_q;
    assign host_fn = host_fn_q;
    assign host_rsvd = host_rsvd_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    a_strap_sync_delay: assert property (
        $past(rstn, 2) |-> strap_s2_q == $past(pci_mode_strap, 2))
        else $error("strap bit does not follow pin after two clocks");

    a_strap_read_back: assert property (
        take && !pwrite && hit1 |=> prdata_q[0] == $past(strap_s2_q))
        else $error("read of strap bit does not show the pin level");

    a_pull_follows: assert property (
        $past(rstn) |-> ipull_en == !$past(strap_s2_q))
        else $error("pull enable does not track the strap");

    a_gpio_blk_sel: assert property (
        $past(rstn) |-> gpio_blk_pci == $past(strap_s2_q))
        else $error("gpio block ownership wrong");

    a_pci_data_off: assert property (
        $past(rstn) |-> pci_data_en == $past(strap_s2_q))
        else $error("pci data block enabled without strap");

    a_emem_pci_gate: assert property (
        $past(rstn) |-> emem_pci ==
            ($past(strap_s2_q) && aem_pci_ok(mem_mode_q)))
        else $error("memory pins pci routing wrong");

    a_host_fn_map: assert property (
        $past(rstn) |-> host_fn == host_decode($past(strap_s2_q), hsel_q))
        else $error("host group function wrong");

    a_host_pci_only: assert property (
        host_fn == pms_pkg::PMS_HOST_PCI |->
            $past(strap_s2_q) && hsel_q == `PMS_HSEL_PCI)
        else $error("host pci without strap and select 000");

    a_hsel_write: assert property (
        wr1 |=> hsel_q == $past(pwdata[6:4]) ##0 host_fn ==
            host_decode($past(strap_s2_q), $past(pwdata[6:4])))
        else $error("host select write not applied at once");

    a_ready_pulse: assert property (
        take |=> pready_q ##1 !pready_q)
        else $error("answer is not a single cycle");

    a_ready_needs_req: assert property (
        pready_q |-> $past(take))
        else $error("answer without a taken request");

    a_idle_quiet: assert property (
        !pready_q |-> !pslverr_q && prdata_q == 32'h0000_0000)
        else $error("read data or error outside the answer cycle");

    a_unmapped_err: assert property (
        take && !hit0 && !hit1 |=> pslverr_q && prdata_q == 32'h0000_0000)
        else $error("unmapped access not refused");

    a_mapped_no_err: assert property (
        take && (hit0 || hit1) |=> !pslverr_q)
        else $error("error flagged on a mapped register");

    a_sel0_read: assert property (
        take && !pwrite && hit0 |=>
            prdata_q == {29'h0, $past(mem_mode_q)})
        else $error("read of memory pin mode wrong");

    a_sel1_fields: assert property (
        take && !pwrite && hit1 |=>
            prdata_q[31:1] == {25'h0, $past(hsel_q), 3'h0})
        else $error("read of host select or reserved bits wrong");

    a_strap_ro: assert property (
        wr1 |=> strap_s2_q == $past(strap_s1_q))
        else $error("write disturbed the strap bit");

    a_sync_first_stage: assert property (
        $past(rstn) |-> strap_s1_q == $past(pci_mode_strap))
        else $error("first strap stage does not follow the pin");

    a_mode_write: assert property (
        wr0 |=> mem_mode_q == $past(pwdata[2:0]) ##0
            emem_mode == $past(pwdata[2:0]))
        else $error("memory pin mode write not applied at once");

    a_mode_hold: assert property (
        !wr0 |=> mem_mode_q == $past(mem_mode_q))
        else $error("memory pin mode changed without a write");

    a_hsel_hold: assert property (
        !wr1 |=> hsel_q == $past(hsel_q))
        else $error("host select changed without a write");

    a_emem_mode_copy: assert property (
        emem_mode == mem_mode_q)
        else $error("memory group function differs from its field");

    a_emem_mode_gate: assert property (
        emem_pci |-> aem_pci_ok(emem_mode))
        else $error("memory pins pci in a non pci pin mode");

    a_pci_owns_pins: assert property (
        $past(rstn) && $past(strap_s2_q) |->
            !ipull_en && gpio_blk_pci && pci_data_en)
        else $error("strap high but pins not all pci");

    a_no_pci_low: assert property (
        $past(rstn) && !$past(strap_s2_q) |->
            ipull_en && !emem_pci && host_fn != pms_pkg::PMS_HOST_PCI)
        else $error("pci function present with strap low");

    a_gpio_mode_low: assert property (
        $past(rstn) && !$past(strap_s2_q) |-> !gpio_blk_pci)
        else $error("gpio block not gpio with strap low");

    a_data_off_low: assert property (
        $past(rstn) && !$past(strap_s2_q) |-> !pci_data_en)
        else $error("pci data block active with strap low");

    a_data_tracks_gpio: assert property (
        pci_data_en == gpio_blk_pci)
        else $error("pci data and gpio block ownership disagree");

    a_host_joint: assert property (
        $past(rstn) && !$past(strap_s2_q) && hsel_q == `PMS_HSEL_PCI |->
            host_fn == pms_pkg::PMS_HOST_GPIO)
        else $error("host select alone gave a pci function");

    a_host_rsvd_flag: assert property (
        host_rsvd == (host_fn == pms_pkg::PMS_HOST_RSVD))
        else $error("reserved flag disagrees with host function");

    c_host_pci: cover property (host_fn == pms_pkg::PMS_HOST_PCI);
    c_emem_pci: cover property (emem_pci && emem_mode == 3'h5);
    c_read_sel1: cover property (take && !pwrite && hit1);
    c_unmapped: cover property (pslverr_q);
    c_host_rsvd: cover property (host_rsvd);

endmodule

/* pkg/pms_cfg.svh */
`ifndef PMS_CFG_SVH
`define PMS_CFG_SVH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define PMS_ADDR_W 12
`define PMS_OFF_SEL0 12'h000
`define PMS_OFF_SEL1 12'h004

// ----------------------------------------
// field positions
// ----------------------------------------
`define PMS_MEM_MODE_LSB 0
`define PMS_MEM_MODE_MSB 2
`define PMS_STRAP_BIT 0
`define PMS_HSEL_LSB 4
`define PMS_HSEL_MSB 6

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define PMS_MEM_MODE_RST 3'h0
`define PMS_HSEL_RST 3'h0
`define PMS_MEM_PCI_A 3'h0
`define PMS_MEM_PCI_B 3'h5
`define PMS_HSEL_PCI 3'h0

`endif

/* pkg/pms_pkg.sv */
package pms_pkg;

    typedef enum logic [2:0] {
        PMS_HOST_GPIO = 3'b000,
        PMS_HOST_HPI = 3'b001,
        PMS_HOST_LINK = 3'b010,
        PMS_HOST_LINK_MII = 3'b011,
        PMS_HOST_MII = 3'b100,
        PMS_HOST_PCI = 3'b101,
        PMS_HOST_RSVD = 3'b111
    } pms_host_fn_t;

endpackage

/* sim/pci_strap_pin_mux_tb_top.sv */
`timescale 1ns/1ps
module pci_strap_pin_mux_tb_top;
// ----------------------------------------
// signals
// ----------------------------------------
logic mclk = 1'b0;
logic rstn = 1'b0;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0000_0000;
logic pci_mode_strap = 1'b0;
logic [31:0] prdata;
logic pready, pslverr, ipull_en, gpio_blk_pci, pci_data_en;
logic emem_pci, host_rsvd;
logic [2:0] emem_mode;
pms_pkg::pms_host_fn_t host_fn;
int error_cnt = 0;
int cmp_count = 0;
int seed = 32'h3d1f_dcf7;
int i, n;
logic [2:0] m_mode, m_hs;
logic [31:0] rd;
logic err, st;
logic [11:0] ra;
always #5 mclk = ~mclk;
pms_top i_pms_top (.mclk(mclk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pci_mode_strap(pci_mode_strap), .ipull_en(ipull_en),
    .gpio_blk_pci(gpio_blk_pci), .pci_data_en(pci_data_en),
    .emem_pci(emem_pci), .emem_mode(emem_mode), .host_fn(host_fn),
    .host_rsvd(host_rsvd));
// ----------------------------------------
// helpers
// ----------------------------------------
function automatic logic [3:0] exp_host(input logic s, input logic [2:0] h);
    if (s && h == 3'h0) return {1'b0, pms_pkg::PMS_HOST_PCI};
    if (!s && h <= 3'h4) return {1'b0, h};
    return {1'b1, pms_pkg::PMS_HOST_RSVD};
endfunction
task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    cmp_count++;
    if (seen !== ex) begin
        error_cnt++;
        $display("[FAIL] %s expected %h seen %h", nm, ex, seen);
    end
endtask
// requests are held until pready is seen high at a rising edge
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    // answer is read as sampled at the rising edge, then released
    do begin
        @(posedge mclk);
        n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk("wr_err", err, a > 12'h004);
    if (a == 12'h000) m_mode = d[2:0];
    if (a == 12'h004) m_hs = d[6:4];
endtask
task verify;
    apb(1'b0, 12'h000, 32'h0); chk("sel0", rd, {29'h0, m_mode});
    apb(1'b0, 12'h004, 32'h0); chk("sel1", rd, {25'h0, m_hs, 3'h0, st});
    @(negedge mclk);
    chk("ipull", ipull_en, !st);
    chk("gpio_blk", gpio_blk_pci, st);
    chk("pci_data", pci_data_en, st);
    chk("emem_pci", emem_pci, st && (m_mode == 3'h0 || m_mode == 3'h5));
    chk("emem_mode", emem_mode, m_mode);
    chk("host", {host_rsvd, host_fn}, exp_host(st, m_hs));
endtask
task close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
// ----------------------------------------
// main sequence
// ----------------------------------------
initial begin
    for (int s = 0; s < 2; s++) begin
        st = s[0];
        // strap only moves under reset, as the board must keep it static
        @(posedge mclk);
        rstn <= 1'b0;
        pci_mode_strap <= st;
        repeat (16) @(posedge mclk);
        chk("rst_pull", ipull_en, 1'b1);
        chk("rst_host", host_fn, 3'h0);
        rstn <= 1'b1;
        // pins follow the read bit one edge later: third edge
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        chk("sync1", gpio_blk_pci, 1'b0);
        @(negedge mclk);
        chk("sync2", gpio_blk_pci, st);
        m_mode = 3'h0;
        m_hs = 3'h0;
        verify;
        for (i = 0; i < 8; i++) begin
            wr(12'h004, {25'h0, i[2:0], 4'hf});
            wr(12'h000, {29'h0, i[2:0]});
            verify;
        end
        for (i = 0; i < 24; i++) begin
            ra = 12'($random(seed)) & 12'h00c;
            wr(ra, $random(seed));
            verify;
        end
        $display("test strap %0d done", s);
    end
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped_rd", rd, 32'h0);
    chk("unmapped_err", err, 1'b1);
    $display("test unmapped done");
    close_out;
end
initial begin
    #200000;
    error_cnt++;
    $display("watchdog expired");
    close_out;
end
endmodule
